// ==== core/sdc_pkg.sv ====
package sdc_pkg;

  localparam int unsigned LOOP_DIV_W    = 9;
  localparam int unsigned OUT_SEL_W     = 2;
  localparam int unsigned TEST_SEL_W    = 3;
  localparam int unsigned SHIFT_LEN     = 14;
  localparam int unsigned HALF_W        = 3;

  // serial word layout, last bit shifted lands in bit 0
  localparam int unsigned SH_LOOP_LSB   = 0;
  localparam int unsigned SH_OUT_LSB    = 9;
  localparam int unsigned SH_TEST_LSB   = 11;
  localparam int unsigned SH_MSB        = 13;

  // fixed prescale of 8 is a half period of 4 source edges
  localparam logic [HALF_W-1:0] PRESCALE_HALF = 3'h4;
  // divide by 4 for the test view of the output
  localparam logic [HALF_W-1:0] TEST_Q_HALF   = 3'h2;

  // output divider select codes
  localparam logic [OUT_SEL_W-1:0] OSEL_DIV2 = 2'h0;
  localparam logic [OUT_SEL_W-1:0] OSEL_DIV4 = 2'h1;
  localparam logic [OUT_SEL_W-1:0] OSEL_DIV8 = 2'h2;
  localparam logic [OUT_SEL_W-1:0] OSEL_DIV1 = 2'h3;

  // test output select codes
  localparam logic [TEST_SEL_W-1:0] TSEL_SHIFT  = 3'h0;
  localparam logic [TEST_SEL_W-1:0] TSEL_HIGH   = 3'h1;
  localparam logic [TEST_SEL_W-1:0] TSEL_REF    = 3'h2;
  localparam logic [TEST_SEL_W-1:0] TSEL_LOOP   = 3'h3;
  localparam logic [TEST_SEL_W-1:0] TSEL_OUT    = 3'h4;
  localparam logic [TEST_SEL_W-1:0] TSEL_LOW    = 3'h5;
  localparam logic [TEST_SEL_W-1:0] TSEL_BYPASS = 3'h6;
  localparam logic [TEST_SEL_W-1:0] TSEL_OUTQ   = 3'h7;

  localparam logic [TEST_SEL_W-1:0] TEST_RST    = 3'h0;
  localparam logic [LOOP_DIV_W-1:0] LOOP_RST    = 9'h000;
  localparam logic [OUT_SEL_W-1:0]  OSEL_RST    = 2'h0;

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction : rise

  // half period in source edges; zero means pass through
  function automatic logic [HALF_W-1:0] out_half(input logic [OUT_SEL_W-1:0] sel);
    if (sel == OSEL_DIV2)
      out_half = 3'h1;
    else if (sel == OSEL_DIV4)
      out_half = 3'h2;
    else if (sel == OSEL_DIV8)
      out_half = 3'h4;
    else
      out_half = 3'h0;
  endfunction : out_half

endpackage : sdc_pkg

// ==== core/sdc_half_div.sv ====
`timescale 1ns/100ps
`default_nettype none

// even divider with 50% duty: toggles every half_i rising source edges; a half_i of zero passes src_i through registered, one clock later
module sdc_half_div #(
  parameter int unsigned HW = 3
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          src_i,
  input  wire logic [HW-1:0] half_i,
  output logic               div_o
);

  logic          prev_r;
  logic [HW-1:0] cnt_r;
  logic [HW-1:0] cnt_nxt;
  logic          div_r;
  logic          div_nxt;
  wire  logic    src_rise = sdc_pkg::rise(src_i, prev_r);
  wire  logic    pass     = (half_i == '0);
  wire  logic    wrap     = (cnt_r + HW'(1)) >= half_i;

  always_comb
  begin
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    if (pass)
    begin
      cnt_nxt = '0;
      div_nxt = src_i;
    end
    else if (src_rise)
    begin
      cnt_nxt = wrap ? '0 : cnt_r + HW'(1);
      div_nxt = wrap ? ~div_r : div_r;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prev_r <= 1'b0;
      cnt_r  <= '0;
      div_r  <= 1'b0;
    end
    else
    begin
      prev_r <= src_i;
      cnt_r  <= cnt_nxt;
      div_r  <= div_nxt;
    end
  end

  assign div_o = div_r;

endmodule : sdc_half_div
`default_nettype wire

// ==== core/sdc_synth_divider_config.sv ====
`timescale 1ns/100ps
`default_nettype none

module sdc_synth_divider_config #(
  parameter int unsigned MW = sdc_pkg::LOOP_DIV_W
) (
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          crystal_oscillator_pins_i,
  input  wire logic                          external_reference_input_i,
  input  wire logic                          reference_source_select_i,
  input  wire logic                          vco_clk_i,
  input  wire logic [MW-1:0]                 loop_div_i,
  input  wire logic [sdc_pkg::OUT_SEL_W-1:0] out_div_sel_i,
  input  wire logic                          p_load_i,
  input  wire logic                          s_clock_i,
  input  wire logic                          s_data_i,
  input  wire logic                          s_load_i,
  input  wire logic                          out_enable_i,
  output logic                               comparison_ref_o,
  output logic                               loop_div_out_o,
  output logic                               pd_up_o,
  output logic                               pd_down_o,
  output logic                               synth_output_pair_p_o,
  output logic                               synth_output_pair_n_o,
  output logic                               test_out_o,
  output logic [MW-1:0]                      loop_div_cfg_o,
  output logic [sdc_pkg::OUT_SEL_W-1:0]      out_div_cfg_o,
  output logic                               bypass_o
);

  logic [sdc_pkg::SHIFT_LEN-1:0]  shift_r;
  logic                           sclk_prev_r;
  logic [MW-1:0]                  loop_cfg_r;
  logic [sdc_pkg::OUT_SEL_W-1:0]  osel_cfg_r;
  logic [sdc_pkg::TEST_SEL_W-1:0] test_cfg_r;
  logic [MW-1:0]                  loop_cnt_r;
  logic [MW-1:0]                  loop_cnt_nxt;
  logic                           loop_src_prev_r;
  logic                           loop_pulse_r;
  logic                           fref_prev_r;
  logic                           mdiv_prev_r;
  logic                           up_r;
  logic                           dn_r;
  logic                           gate_r;
  logic                           outdiv_prev_r;
  logic                           test_r;
  logic                           fref;
  logic                           out_div;
  logic                           out_quarter;

  // shift register, msb of each field first so the last bit ends in bit 0
  wire logic sclk_rise = sdc_pkg::rise(s_clock_i, sclk_prev_r);

  // config latch selection: parallel transparent low, serial transparent high
  wire logic ser_open = p_load_i & s_load_i;
  wire logic [MW-1:0] sh_loop = shift_r[sdc_pkg::SH_LOOP_LSB +: MW];
  wire logic [sdc_pkg::OUT_SEL_W-1:0] sh_osel =
    shift_r[sdc_pkg::SH_OUT_LSB +: sdc_pkg::OUT_SEL_W];
  wire logic [sdc_pkg::TEST_SEL_W-1:0] sh_test =
    shift_r[sdc_pkg::SH_TEST_LSB +: sdc_pkg::TEST_SEL_W];

  // latched value holds from the closing edge; parallel checked first
  wire logic [MW-1:0] loop_eff =
    !p_load_i ? loop_div_i : (ser_open ? sh_loop : loop_cfg_r);
  wire logic [sdc_pkg::OUT_SEL_W-1:0] osel_eff =
    !p_load_i ? out_div_sel_i : (ser_open ? sh_osel : osel_cfg_r);
  wire logic [sdc_pkg::TEST_SEL_W-1:0] test_eff =
    !p_load_i ? sdc_pkg::TEST_RST : (ser_open ? sh_test : test_cfg_r);

  wire logic bypass   = (test_eff == sdc_pkg::TSEL_BYPASS);
  wire logic ref_sel  = reference_source_select_i ? crystal_oscillator_pins_i
                                                  : external_reference_input_i;
  // in bypass the serial clock replaces the vco for both dividers
  wire logic loop_src = bypass ? s_clock_i : vco_clk_i;
  wire logic loop_rise = sdc_pkg::rise(loop_src, loop_src_prev_r);
  wire logic loop_wrap = (loop_cnt_r + MW'(1)) >= loop_eff;
  wire logic fref_rise = sdc_pkg::rise(fref, fref_prev_r);
  wire logic mdiv_rise = sdc_pkg::rise(loop_pulse_r, mdiv_prev_r);

  sdc_half_div #(
    .HW (sdc_pkg::HALF_W)
  ) u_prescale (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .src_i    (ref_sel),
    .half_i   (sdc_pkg::PRESCALE_HALF),
    .div_o    (fref)
  );

  sdc_half_div #(
    .HW (sdc_pkg::HALF_W)
  ) u_out_div (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .src_i    (loop_src),
    .half_i   (sdc_pkg::out_half(osel_eff)),
    .div_o    (out_div)
  );

  sdc_half_div #(
    .HW (sdc_pkg::HALF_W)
  ) u_out_quarter (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .src_i    (out_div),
    .half_i   (sdc_pkg::TEST_Q_HALF),
    .div_o    (out_quarter)
  );

  // loop counter; values 0 and 1 both give one pulse per source edge
  always_comb
  begin
    loop_cnt_nxt = loop_cnt_r;
    if (loop_rise)
      loop_cnt_nxt = loop_wrap ? '0 : loop_cnt_r + MW'(1);
  end

  // test mux; the loop counter view is not 50% duty
  wire logic test_nxt =
    (test_eff == sdc_pkg::TSEL_SHIFT)  ? shift_r[sdc_pkg::SH_MSB] :
    (test_eff == sdc_pkg::TSEL_HIGH)   ? 1'b1 :
    (test_eff == sdc_pkg::TSEL_REF)    ? fref :
    (test_eff == sdc_pkg::TSEL_LOOP)   ? loop_pulse_r :
    (test_eff == sdc_pkg::TSEL_OUT)    ? out_div :
    (test_eff == sdc_pkg::TSEL_BYPASS) ? loop_pulse_r :
    (test_eff == sdc_pkg::TSEL_OUTQ)   ? out_quarter : 1'b0;

  // gate may only move while the divided clock is low, so no runt escapes
  wire logic gate_nxt =
    (sdc_pkg::rise(out_div, outdiv_prev_r) || out_div) ? gate_r : out_enable_i;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shift_r     <= '0;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      sclk_prev_r <= s_clock_i;
      if (sclk_rise)
        shift_r <= {shift_r[sdc_pkg::SHIFT_LEN-2:0], s_data_i};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      loop_cfg_r <= sdc_pkg::LOOP_RST;
      osel_cfg_r <= sdc_pkg::OSEL_RST;
      test_cfg_r <= sdc_pkg::TEST_RST;
    end
    else
    begin
      loop_cfg_r <= loop_eff;
      osel_cfg_r <= osel_eff;
      test_cfg_r <= test_eff;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      loop_cnt_r      <= '0;
      loop_src_prev_r <= 1'b0;
      loop_pulse_r    <= 1'b0;
    end
    else
    begin
      loop_cnt_r      <= loop_cnt_nxt;
      loop_src_prev_r <= loop_src;
      loop_pulse_r    <= loop_rise & loop_wrap;
    end
  end

  // phase-frequency detector: leader raises its flag, the lagging edge clears it, so both are never high together
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fref_prev_r <= 1'b0;
      mdiv_prev_r <= 1'b0;
      up_r        <= 1'b0;
      dn_r        <= 1'b0;
    end
    else
    begin
      fref_prev_r <= fref;
      mdiv_prev_r <= loop_pulse_r;
      up_r        <= (up_r | fref_rise) & ~(dn_r | mdiv_rise);
      dn_r        <= (dn_r | mdiv_rise) & ~(up_r | fref_rise);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gate_r        <= 1'b0;
      outdiv_prev_r <= 1'b0;
      test_r        <= 1'b0;
    end
    else
    begin
      gate_r        <= gate_nxt;
      outdiv_prev_r <= out_div;
      test_r        <= test_nxt;
    end
  end

  assign comparison_ref_o      = fref;
  assign loop_div_out_o        = loop_pulse_r;
  assign pd_up_o               = up_r;
  assign pd_down_o             = dn_r;
  assign synth_output_pair_p_o = out_div & gate_r;
  assign synth_output_pair_n_o = ~(out_div & gate_r);
  assign test_out_o            = test_r;
  assign loop_div_cfg_o        = loop_cfg_r;
  assign out_div_cfg_o         = osel_cfg_r;
  assign bypass_o              = bypass;

endmodule : sdc_synth_divider_config
`default_nettype wire

// ==== verification/sdc_cfg_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdc_cfg_monitor #(
  parameter int unsigned MW = 9
) (
  input wire logic                          clk_i,
  input wire logic                          resetn_i,
  input wire logic [MW-1:0]                 loop_div_i,
  input wire logic [sdc_pkg::OUT_SEL_W-1:0] out_div_sel_i,
  input wire logic                          p_load_i,
  input wire logic                          s_load_i,
  input wire logic                          loop_div_out_o,
  input wire logic                          pd_up_o,
  input wire logic                          pd_down_o,
  input wire logic                          synth_output_pair_p_o,
  input wire logic                          synth_output_pair_n_o,
  input wire logic [MW-1:0]                 loop_div_cfg_o,
  input wire logic [sdc_pkg::OUT_SEL_W-1:0] out_div_cfg_o,
  input wire logic                          bypass_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  par_follow_a: assert property (!p_load_i |=> loop_div_cfg_o == $past(loop_div_i))
    else $error("loop config not following parallel input");
  sel_follow_a: assert property (!p_load_i |=> out_div_cfg_o == $past(out_div_sel_i))
    else $error("output select config not following parallel input");
  cfg_hold_a: assert property (p_load_i && !s_load_i |=> $stable({out_div_cfg_o, loop_div_cfg_o}))
    else $error("config changed while latches closed");
  test_clr_a: assert property (!p_load_i && !$past(p_load_i) |-> !bypass_o)
    else $error("bypass active while parallel load low");
  byp_cause_a: assert property ($changed(bypass_o) |-> $changed(p_load_i) || s_load_i
    || $past(s_load_i) || $past(p_load_i) != $past(p_load_i, 2))
    else $error("bypass changed without a load");
  pair_comp_a: assert property (synth_output_pair_n_o == !synth_output_pair_p_o)
    else $error("output pair not complementary");
  pd_clear_a: assert property (pd_up_o && pd_down_o |=> !pd_up_o && !pd_down_o)
    else $error("detector flags not cleared");
  loop_pulse_a: assert property (loop_div_out_o |=> !loop_div_out_o)
    else $error("loop divider pulse longer than one cycle");
endmodule : sdc_cfg_monitor
`default_nettype wire

// ==== verification/sdc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model (
  input  wire logic clk_i,
  output logic [8:0] loop_div_i,
  output logic [1:0] out_div_sel_i,
  output logic       p_load_i,
  output logic       s_clock_i,
  output logic       s_data_i,
  output logic       s_load_i
);
  // serial lines idle low, as their pulldowns would leave them
  initial {loop_div_i, out_div_sel_i, p_load_i, s_clock_i, s_data_i, s_load_i} = '0;
  task automatic step;
    @(posedge clk_i);
    #2;
  endtask : step
  task automatic par(input logic [8:0] m, input logic [1:0] n, input logic pl);
    step();
    loop_div_i    = m;
    out_div_sel_i = n;
    p_load_i      = pl;
  endtask : par
  task automatic ser(input logic [13:0] w);
    for (int i = 13; i >= 0; i--)
    begin
      step();
      s_data_i  = w[i];
      s_clock_i = 1'b0;
      step();
      s_clock_i = 1'b1;
    end
    step();
    s_clock_i = 1'b0;
    s_load_i  = 1'b1;
    repeat (2) step();
    s_load_i = 1'b0;
    step();
    s_data_i = 1'b0;
  endtask : ser
endmodule : sdc_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       crystal_oscillator_pins_i = 1'b0;
  logic       external_reference_input_i = 1'b0;
  logic       reference_source_select_i = 1'b1;
  logic       vco_clk_i = 1'b0;
  logic       out_enable_i = 1'b1;
  logic [2:0] ph = 3'h0;
  wire  [8:0] loop_div_i, loop_div_cfg_o;
  wire  [1:0] out_div_sel_i, out_div_cfg_o;
  wire        p_load_i, s_clock_i, s_data_i, s_load_i, comparison_ref_o, loop_div_out_o;
  wire        pd_up_o, pd_down_o, synth_output_pair_p_o, synth_output_pair_n_o;
  wire        test_out_o, bypass_o;
  int         error_cnt = 0, num_checks = 0, rr = 0, orr = 0, hc = 0, tcnt = 0;
  int         lr = 0, tr = 0;
  sdc_synth_divider_config sdc_synth_divider_config_i (
    .clk_i                      (clk_i),
    .resetn_i                   (resetn_i),
    .crystal_oscillator_pins_i  (crystal_oscillator_pins_i),
    .external_reference_input_i (external_reference_input_i),
    .reference_source_select_i  (reference_source_select_i),
    .vco_clk_i                  (vco_clk_i),
    .loop_div_i                 (loop_div_i),
    .out_div_sel_i              (out_div_sel_i),
    .p_load_i                   (p_load_i),
    .s_clock_i                  (s_clock_i),
    .s_data_i                   (s_data_i),
    .s_load_i                   (s_load_i),
    .out_enable_i               (out_enable_i),
    .comparison_ref_o           (comparison_ref_o),
    .loop_div_out_o             (loop_div_out_o),
    .pd_up_o                    (pd_up_o),
    .pd_down_o                  (pd_down_o),
    .synth_output_pair_p_o      (synth_output_pair_p_o),
    .synth_output_pair_n_o      (synth_output_pair_n_o),
    .test_out_o                 (test_out_o),
    .loop_div_cfg_o             (loop_div_cfg_o),
    .out_div_cfg_o              (out_div_cfg_o),
    .bypass_o                   (bypass_o)
  );
  sdc_host_model host (
    .clk_i         (clk_i),
    .loop_div_i    (loop_div_i),
    .out_div_sel_i (out_div_sel_i),
    .p_load_i      (p_load_i),
    .s_clock_i     (s_clock_i),
    .s_data_i      (s_data_i),
    .s_load_i      (s_load_i)
  );
  always #12.5 clk_i = ~clk_i;
  // vco and crystal at a quarter of clk, external at an eighth
  always @(posedge clk_i)
  begin
    #2;
    ph = ph + 3'h1;
    vco_clk_i = ph[1];
    crystal_oscillator_pins_i = ph[1];
    external_reference_input_i = ph[2];
    hc = hc + int'(synth_output_pair_p_o);
    tcnt++;
    if (tcnt == 12000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  always @(posedge comparison_ref_o) rr++;
  always @(posedge synth_output_pair_p_o) orr++;
  always @(posedge loop_div_out_o) lr++;
  always @(posedge test_out_o) tr++;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int t);
    num_checks++;
    if ($isunknown(g) || (t == 0 ? (g !== e) : (g > e + t || g + t < e)))
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic t_ref;
    for (int s = 1; s >= 0; s--)
    begin
      reference_source_select_i = s[0];
      cyc(70);
      rr = 0;
      cyc(512);
      chk(rr, s ? 16 : 8, 1);
    end
    $display("reference test done");
  endtask : t_ref
  task automatic t_par;
    host.par(9'h106, 2'h1, 1'b0);
    cyc(3);
    chk({out_div_cfg_o, loop_div_cfg_o}, {2'h1, 9'h106}, 0);
    host.par(9'h106, 2'h1, 1'b1);
    host.par(9'h0a5, 2'h2, 1'b1);
    cyc(3);
    chk({out_div_cfg_o, loop_div_cfg_o}, {2'h1, 9'h106}, 0);
    $display("parallel test done");
  endtask : t_par
  task automatic t_ser;
    host.ser({sdc_pkg::TSEL_HIGH, 2'h3, 9'h0c3});
    cyc(3);
    chk({test_out_o, out_div_cfg_o, loop_div_cfg_o}, {1'b1, 2'h3, 9'h0c3}, 0);
    host.ser({sdc_pkg::TSEL_LOW, 2'h3, 9'h0c3});
    cyc(3);
    chk(test_out_o, 1'b0, 0);
    host.ser({sdc_pkg::TSEL_BYPASS, 2'h0, 9'h002});
    cyc(3);
    chk(bypass_o, 1'b1, 0);
    // in bypass the 14 serial clock rises drive both dividers, vco is ignored
    orr = 0;
    tr = 0;
    host.ser({sdc_pkg::TSEL_BYPASS, 2'h0, 9'h002});
    chk(orr, 7, 1);
    chk(tr, 7, 1);
    host.par(9'h1f0, 2'h2, 1'b0);
    host.ser({sdc_pkg::TSEL_BYPASS, 2'h1, 9'h003});
    chk({bypass_o, out_div_cfg_o, loop_div_cfg_o}, {1'b0, 2'h2, 9'h1f0}, 0);
    host.par(9'h1f0, 2'h2, 1'b1);
    $display("serial test done");
  endtask : t_ser
  task automatic t_out;
    int exp_r[4] = '{64, 32, 16, 128};
    for (int s = 0; s < 5; s++)
    begin
      host.par(9'h010, s[1:0], 1'b0);
      host.par(9'h010, s[1:0], 1'b1);
      out_enable_i = (s != 4);
      cyc(40);
      orr = 0;
      hc = 0;
      lr = 0;
      cyc(512);
      chk(orr, s == 4 ? 0 : exp_r[s % 4], s == 4 ? 0 : 1);
      chk(hc, s == 4 ? 0 : 256, s == 4 ? 0 : 4);
      chk(lr, 8, 1);
    end
    $display("output divider test done");
  endtask : t_out
  // reference select is left low by t_ref, so the reference view runs at ext/8
  task automatic t_test;
    logic [2:0] code [4] = '{sdc_pkg::TSEL_REF, sdc_pkg::TSEL_OUT,
                             sdc_pkg::TSEL_OUTQ, sdc_pkg::TSEL_LOOP};
    int exp_t[4] = '{8, 64, 16, 8};
    for (int k = 0; k < 4; k++)
    begin
      host.ser({code[k], sdc_pkg::OSEL_DIV2, 9'h010});
      cyc(70);
      tr = 0;
      cyc(512);
      chk(tr, exp_t[k], 1);
    end
    $display("test output test done");
  endtask : t_test
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    cyc(2);
    resetn_i = 1'b1;
    t_ref();
    t_par();
    t_ser();
    t_out();
    t_test();
    give_verdict();
  end
endmodule : tb_top
bind sdc_synth_divider_config sdc_cfg_monitor #(.MW(MW)) sdc_cfg_monitor_i (
  .clk_i                 (clk_i),
  .resetn_i              (resetn_i),
  .loop_div_i            (loop_div_i),
  .out_div_sel_i         (out_div_sel_i),
  .p_load_i              (p_load_i),
  .s_load_i              (s_load_i),
  .loop_div_out_o        (loop_div_out_o),
  .pd_up_o               (pd_up_o),
  .pd_down_o             (pd_down_o),
  .synth_output_pair_p_o (synth_output_pair_p_o),
  .synth_output_pair_n_o (synth_output_pair_n_o),
  .loop_div_cfg_o        (loop_div_cfg_o),
  .out_div_cfg_o         (out_div_cfg_o),
  .bypass_o              (bypass_o)
);
`default_nettype wire
